/* File: logic/fbw_wdog.v */
`timescale 1ns/1ps
`include "fbw_defs.vh"

// What this block does
// - Trigger only when written value differs
// - Nonzero trigger write starts idle watchdog
// - Fault clears the trigger register
// - Trigger keeps smaller remaining time; reset ffff
// - Minimum counted in 100 ms units
// - Minimum write only overwrites stored value
// - aaaa then 5555 stops, clears fault
// - Running register reads 0 or 1
// - Writing 1 restarts after timeout
// - No restart after software stop
// - aa55 or 55aa stops, clears fault
// - Only single-word accesses accepted
// - Mask bit four: Force Single Coil triggers
// - Timeout nonzero to start, locked while running
// - Mask bit n-1 enables code n
module fbw_wdog #(
	parameter TICK_CYCLES = `FBW_TICK_CYCLES,
	parameter [15:0] FC_SUPPORTED = 16'hffff
) (
	input wire core_clk,
	input wire rst,
	input wire reg_rd,
	input wire reg_wr,
	input wire [15:0] reg_addr,
	input wire [7:0] reg_count,
	input wire [15:0] reg_wdata,
	input wire fc_valid,
	input wire [7:0] fc_code,
	output reg reg_ack_q,
	output reg reg_err_q,
	output reg [15:0] reg_rdata_q,
	output reg wd_fault_q,
	output reg pd_write_en_q,
	output reg running_flag_q
);

	////////////////////////////////////////////////////////////////////////////
	// Storage

	// Stored words, trigger and minimum also set by the logic, plus the live countdown
	reg [15:0] timeout_value_q; // Timeout in 100 ms counts
	reg [15:0] fc_mask_lo_q; // Codes 1..16
	reg [15:0] fc_mask_hi_q; // Codes 17..32, none supported
	reg [15:0] trigger_q; // Last trigger word
	reg [15:0] min_time_q; // Least remaining time seen
	reg [15:0] keyed_stop_q; // Last keyed stop word
	reg [15:0] restart_q; // Restart command word
	reg [15:0] simple_stop_q; // Last simple stop word
	reg [15:0] remain_q; // Down-counter, 100 ms per count
	reg key_armed_q; // First key word seen

	wire tick; // 100 ms enable
	// Request qualifiers; a write only counts when it carries one word,
	// so a refused multi-word write can never retrigger or stop
	wire acc = reg_rd | reg_wr;
	wire single = (reg_count == `FBW_WORDS_PER_ACCESS);
	wire wr = reg_wr & single; // Legal write

	////////////////////////////////////////////////////////////////////////////
	// Decode

	// Exact decode; a gap in the map answers with an error
	reg mapped; // Address inside the block
	always @* begin
		case (reg_addr)
			`FBW_ADDR_TIMEOUT, `FBW_ADDR_MASK_LO, `FBW_ADDR_MASK_HI,
			`FBW_ADDR_TRIGGER, `FBW_ADDR_MIN_TIME, `FBW_ADDR_KEYED_STOP,
			`FBW_ADDR_RUNNING, `FBW_ADDR_RESTART, `FBW_ADDR_SIMPLE_STOP: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// One write strobe per register, all gated by the legal-write qualifier;
	// the running-flag address has no strobe, so writes to it do nothing
	wire wr_timeout = wr & (reg_addr == `FBW_ADDR_TIMEOUT);
	wire wr_mask_lo = wr & (reg_addr == `FBW_ADDR_MASK_LO);
	wire wr_mask_hi = wr & (reg_addr == `FBW_ADDR_MASK_HI);
	wire wr_trigger = wr & (reg_addr == `FBW_ADDR_TRIGGER);
	wire wr_min = wr & (reg_addr == `FBW_ADDR_MIN_TIME);
	wire wr_keyed = wr & (reg_addr == `FBW_ADDR_KEYED_STOP);
	wire wr_restart = wr & (reg_addr == `FBW_ADDR_RESTART);
	wire wr_simple = wr & (reg_addr == `FBW_ADDR_SIMPLE_STOP);

	////////////////////////////////////////////////////////////////////////////
	// Start, trigger and stop conditions

	// A mask naming an unsupported code never starts the watchdog; the new
	// word is judged as written, together with the upper half already stored
	wire new_mask_ok = ((reg_wdata & ~FC_SUPPORTED) == 16'h0000) &
		(fc_mask_hi_q == 16'h0000);
	wire time_ok = (timeout_value_q != 16'h0000);

	// Start from idle by a nonzero mask or a nonzero trigger word
	wire start_mask = wr_mask_lo & ~running_flag_q & (reg_wdata != 16'h0000) &
		new_mask_ok & time_ok;
	wire start_trig = wr_trigger & ~running_flag_q & (reg_wdata != 16'h0000) &
		time_ok;
	// Restart only out of a timeout; a software stop clears the fault,
	// so a stopped watchdog cannot be revived this way
	wire start_rst = wr_restart & (reg_wdata == `FBW_RESTART_CMD) &
		~running_flag_q & wd_fault_q & time_ok;

	// Codes above 16 belong to the upper mask half, which no code supports,
	// so they are dropped here rather than indexed out of range
	// Function code n enabled by mask bit n-1
	wire [4:0] fc_idx = fc_code[4:0] - 5'h01;
	wire fc_hit = fc_valid & (fc_code != 8'h00) & (fc_code <= 8'h10) &
		fc_mask_lo_q[fc_idx[3:0]];
	// Trigger write counts only with a changed word
	wire trig_hit = wr_trigger & (reg_wdata != trigger_q);
	wire retrig = running_flag_q & (fc_hit | trig_hit);

	// Keyed stop needs the arming word as the previous write to its register
	wire key_stop = wr_keyed & key_armed_q &
		(reg_wdata == `FBW_KEY_SECOND);
	wire simp_key = wr_simple & ((reg_wdata == `FBW_SIMPLE_KEY_A) |
		(reg_wdata == `FBW_SIMPLE_KEY_B));
	wire sw_stop = key_stop | simp_key;

	// Expiry waits for a tick with one count left; a retrigger or stop in
	// the same cycle wins, so a last-moment trigger is never lost
	wire start = start_mask | start_trig | start_rst;
	wire expire = running_flag_q & tick & (remain_q <= 16'h0001) & ~retrig & ~sw_stop;

	////////////////////////////////////////////////////////////////////////////
	// Time base; a load realigns the 100 ms grid

	// Restarting the divider on every load gives the first step a whole
	// 100 ms; the trade is a grid that drifts against any other timer
	fbw_tick #(
		.DIV(TICK_CYCLES)
	) u_tick (
		.core_clk(core_clk),
		.rst(rst),
		.restart(start | retrig),
		.tick(tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Watchdog state

	// Priority: stop, then start or retrigger, then expiry, then the mask
	// write that clears an old fault; a stop also hides an expiry in the
	// same cycle, as a stopped watchdog has no fault reaction
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			running_flag_q <= 1'b0;
			wd_fault_q <= 1'b0;
			pd_write_en_q <= 1'b1;
			remain_q <= `FBW_RST_ZERO;
			key_armed_q <= 1'b0;
		end else begin
			// Key sequence: any other word in between disarms
			if (wr_keyed) begin
				key_armed_q <= (reg_wdata == `FBW_KEY_FIRST);
			end
			if (sw_stop) begin
				// Stop blocks the fault reaction and frees process data
				running_flag_q <= 1'b0;
				wd_fault_q <= 1'b0;
				pd_write_en_q <= 1'b1;
			end else if (start | retrig) begin
				running_flag_q <= 1'b1;
				wd_fault_q <= 1'b0;
				pd_write_en_q <= 1'b1;
				remain_q <= timeout_value_q;
			end else if (expire) begin
				running_flag_q <= 1'b0;
				wd_fault_q <= 1'b1;
				pd_write_en_q <= 1'b0;
				remain_q <= 16'h0000;
			end else if (wr_mask_lo & ~running_flag_q) begin
				// A mask write also clears an old fault
				wd_fault_q <= 1'b0;
				pd_write_en_q <= 1'b1;
			end else if (running_flag_q & tick) begin
				// One count per tick; a load restarts the tick grid
				remain_q <= remain_q - 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Software registers

	// Storage for the master's words; only configuration is locked while running,
	// the rest take any written word, save trigger and minimum in an expiry cycle
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			timeout_value_q <= `FBW_RST_ZERO;
			fc_mask_lo_q <= `FBW_RST_ZERO;
			fc_mask_hi_q <= `FBW_RST_ZERO;
			trigger_q <= `FBW_RST_ZERO;
			min_time_q <= `FBW_RST_MIN_TIME;
			keyed_stop_q <= `FBW_RST_ZERO;
			restart_q <= `FBW_RST_RESTART;
			simple_stop_q <= `FBW_RST_ZERO;
		end else begin
			// Configuration locked while running
			if (wr_timeout & ~running_flag_q) begin
				timeout_value_q <= reg_wdata;
			end
			if (wr_mask_lo & ~running_flag_q) begin
				fc_mask_lo_q <= reg_wdata;
			end
			if (wr_mask_hi & ~running_flag_q) begin
				fc_mask_hi_q <= reg_wdata;
			end
			// Fault wins over a trigger write in the same cycle
			if (expire) begin
				trigger_q <= 16'h0000;
			end else if (wr_trigger) begin
				trigger_q <= reg_wdata;
			end
			// A retrigger compares the time left before its own reload
			// Expiry forces zero so the master sees the overrun
			if (expire) begin
				min_time_q <= 16'h0000;
			end else if (wr_min) begin
				min_time_q <= reg_wdata;
			end else if (retrig & (remain_q < min_time_q)) begin
				min_time_q <= remain_q;
			end
			if (wr_keyed) begin
				keyed_stop_q <= reg_wdata;
			end
			if (wr_restart) begin
				restart_q <= reg_wdata;
			end
			if (wr_simple) begin
				simple_stop_q <= reg_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux

	// Word select for reads; registered with the answer below
	reg [15:0] rd_mux; // Word for the addressed register
	always @* begin
		case (reg_addr)
			`FBW_ADDR_TIMEOUT: begin
				rd_mux = timeout_value_q;
			end
			`FBW_ADDR_MASK_LO: begin
				rd_mux = fc_mask_lo_q;
			end
			`FBW_ADDR_MASK_HI: begin
				rd_mux = fc_mask_hi_q;
			end
			`FBW_ADDR_TRIGGER: begin
				rd_mux = trigger_q;
			end
			`FBW_ADDR_MIN_TIME: begin
				rd_mux = min_time_q;
			end
			`FBW_ADDR_KEYED_STOP: begin
				rd_mux = keyed_stop_q;
			end
			`FBW_ADDR_RUNNING: begin
				rd_mux = running_flag_q ? `FBW_RUN_ACTIVE : 16'h0000;
			end
			`FBW_ADDR_RESTART: begin
				rd_mux = restart_q;
			end
			`FBW_ADDR_SIMPLE_STOP: begin
				rd_mux = simple_stop_q;
			end
			default: begin
				rd_mux = 16'h0000;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Answer, one cycle after the access

	// Multi-word or unmapped accesses answer with an error and change nothing
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_ack_q <= 1'b0;
			reg_err_q <= 1'b0;
			reg_rdata_q <= 16'h0000;
		end else begin
			reg_ack_q <= acc;
			reg_err_q <= acc & (~single | ~mapped);
			// Zero for writes and refusals, so no stale word leaks out
			reg_rdata_q <= (reg_rd & single) ? rd_mux : 16'h0000;
		end
	end

endmodule

/* File: logic/fbw_defs.vh */
`ifndef FBW_DEFS_VH
`define FBW_DEFS_VH

// Word offsets of the watchdog register block
`define FBW_ADDR_TIMEOUT 16'h1000
`define FBW_ADDR_MASK_LO 16'h1001
`define FBW_ADDR_MASK_HI 16'h1002
`define FBW_ADDR_TRIGGER 16'h1003
`define FBW_ADDR_MIN_TIME 16'h1004
`define FBW_ADDR_KEYED_STOP 16'h1005
`define FBW_ADDR_RUNNING 16'h1006
`define FBW_ADDR_RESTART 16'h1007
`define FBW_ADDR_SIMPLE_STOP 16'h1008

// Reset values
`define FBW_RST_ZERO 16'h0000
`define FBW_RST_MIN_TIME 16'hffff
`define FBW_RST_RESTART 16'h0001

// Key and command words
`define FBW_KEY_FIRST 16'haaaa
`define FBW_KEY_SECOND 16'h5555
`define FBW_SIMPLE_KEY_A 16'haa55
`define FBW_SIMPLE_KEY_B 16'h55aa
`define FBW_RESTART_CMD 16'h0001
`define FBW_RUN_ACTIVE 16'h0001

// Only a one-word access is legal
`define FBW_WORDS_PER_ACCESS 8'h01

// Time base: one count is 100 ms, clock period 5 ns
`define FBW_TICK_MS 100
`define FBW_CLK_PERIOD_PS 5000
// Reckoned in ns so the product stays inside 32 bits
`define FBW_TICK_CYCLES ((`FBW_TICK_MS * 1000000) / (`FBW_CLK_PERIOD_PS / 1000))

`endif

/* File: logic/fbw_tick.v */
`timescale 1ns/1ps

// One-cycle enable pulse every DIV clocks, restartable
module fbw_tick #(
	parameter DIV = 20000000
) (
	input wire core_clk,
	input wire rst,
	input wire restart,
	output reg tick
);

	reg [31:0] cnt_q; // Cycles left in the current period

	// Restart realigns the period so a fresh load gets a full first count
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (restart) begin
			cnt_q <= DIV - 1;
			tick <= 1'b0;
		end else if (cnt_q == 32'h0000_0000) begin
			cnt_q <= DIV - 1;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q - 32'h0000_0001;
			tick <= 1'b0;
		end
	end

endmodule

/* File: bench/fbw_wdog_checker.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Watches register answers and watchdog status levels
module fbw_wdog_checker (
	input wire core_clk,
	input wire rst,
	input wire reg_rd,
	input wire reg_wr,
	input wire [15:0] reg_addr,
	input wire [7:0] reg_count,
	input wire [15:0] reg_wdata,
	input wire fc_valid,
	input wire [7:0] fc_code,
	input wire reg_ack_q,
	input wire reg_err_q,
	input wire [15:0] reg_rdata_q,
	input wire wd_fault_q,
	input wire pd_write_en_q,
	input wire running_flag_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Any request, and a legal single-word write
	wire req = reg_rd | reg_wr;
	wire wr1 = reg_wr & (reg_count == 8'h01);
	// Stored timeout is nonzero; it can only change while idle
	reg tmo_nz;
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tmo_nz <= 1'b0;
		end else if (wr1 && reg_addr == 16'h1000 && !running_flag_q) begin
			tmo_nz <= (reg_wdata != 16'h0000);
		end
	end
	AST_ACK: assert property (req |=> reg_ack_q) else $error("ack missing");
	AST_CNT: assert property (
		req && reg_count != 8'h01 |=> reg_err_q) else $error("count not refused");
	AST_MAP: assert property (
		req && (reg_addr < 16'h1000 || reg_addr > 16'h1008) |=> reg_err_q)
		else $error("unmapped not refused");
	// Guard against the level moving in the answer cycle
	AST_RUN_RD: assert property (
		reg_rd && reg_count == 8'h01 && reg_addr == 16'h1006
		##1 $stable(running_flag_q) |-> reg_rdata_q == {15'h0, running_flag_q})
		else $error("running read wrong");
	AST_EXPIRE: assert property (
		$rose(wd_fault_q) |-> !running_flag_q && !pd_write_en_q)
		else $error("expiry effects wrong");
	// Fault only ever leaves through a register write
	AST_HOLD: assert property (
		wd_fault_q && !reg_wr |=> wd_fault_q) else $error("fault dropped");
	AST_SIMPLE: assert property (
		wr1 && reg_addr == 16'h1008 && (reg_wdata == 16'haa55 || reg_wdata == 16'h55aa)
		|=> !running_flag_q && !wd_fault_q && pd_write_en_q) else $error("simple stop");
	AST_KEYED: assert property (
		(wr1 && reg_addr == 16'h1005 && reg_wdata == 16'haaaa)
		##2 (wr1 && reg_addr == 16'h1005 && reg_wdata == 16'h5555)
		|=> !running_flag_q && !wd_fault_q && pd_write_en_q) else $error("keyed stop");
	// A zero timeout blocks any start, a restart too
	AST_RESTART: assert property (
		wr1 && reg_addr == 16'h1007 && reg_wdata == 16'h0001
		&& wd_fault_q && !running_flag_q && tmo_nz |=> running_flag_q) else $error("no restart");
	AST_NO_RST: assert property (
		wr1 && reg_addr == 16'h1007 && !wd_fault_q && !running_flag_q
		|=> !running_flag_q) else $error("restart after stop");
endmodule
bind fbw_wdog fbw_wdog_checker chk (.core_clk(core_clk), .rst(rst), .reg_rd(reg_rd),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_count(reg_count), .reg_wdata(reg_wdata),
	.fc_valid(fc_valid), .fc_code(fc_code), .reg_ack_q(reg_ack_q), .reg_err_q(reg_err_q),
	.reg_rdata_q(reg_rdata_q), .wd_fault_q(wd_fault_q), .pd_write_en_q(pd_write_en_q),
	.running_flag_q(running_flag_q));

/* File: bench/fbw_fc_master.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Master side: served function-code events, one cycle each
module fbw_fc_master (
	input wire core_clk,
	output reg fc_valid,
	output reg [7:0] fc_code
);
	// Idle with no event pending
	initial begin
		fc_valid = 1'b0;
		fc_code = 8'h00;
	end
	// Called at a falling edge; code is scrambled after so no stale match
	task fc(input [7:0] c);
		begin
			fc_valid = 1'b1;
			fc_code = c;
			@(negedge core_clk);
			fc_valid = 1'b0;
			fc_code = ~c;
		end
	endtask
endmodule

/* File: bench/tb_fbw_wdog.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module tb_fbw_wdog;
	reg core_clk, rst, reg_rd, reg_wr;
	reg [15:0] reg_addr, reg_wdata;
	reg [7:0] reg_count;
	wire fc_valid, reg_ack_q, reg_err_q, wd_fault_q, pd_write_en_q, running_flag_q;
	wire [7:0] fc_code;
	wire [15:0] reg_rdata_q;
	integer n_mismatch = 0, n_tests = 0, k;
	reg [15:0] rdv; // Captured answer word
	reg erv; // Captured refusal flag
	// Short tick so a count of 3 expires in about 30 cycles
	fbw_wdog #(.TICK_CYCLES(10)) uut (.core_clk(core_clk), .rst(rst), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_count(reg_count), .reg_wdata(reg_wdata),
		.fc_valid(fc_valid), .fc_code(fc_code), .reg_ack_q(reg_ack_q), .reg_err_q(reg_err_q),
		.reg_rdata_q(reg_rdata_q), .wd_fault_q(wd_fault_q), .pd_write_en_q(pd_write_en_q),
		.running_flag_q(running_flag_q));
	fbw_fc_master m (.core_clk(core_clk), .fc_valid(fc_valid), .fc_code(fc_code));
	initial begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////
	// One compare for every result kind
	task chk(input string s, input [15:0] e, input [15:0] g);
		begin
			n_tests++;
			if (g !== e) begin
				n_mismatch++;
				$display("wrong value %s exp %h got %h", s, e, g);
			end
		end
	endtask
	// One-cycle request from a falling edge; the answer stands for the next
	// cycle only, so it is taken at the next falling edge, then an edge idles
	task bus(input w, input [15:0] a, input [15:0] d, input [7:0] n);
		begin
			reg_wr = w;
			reg_rd = !w;
			reg_addr = a;
			reg_wdata = d;
			reg_count = n;
			@(negedge core_clk);
			chk("ack", 1, {15'h0, reg_ack_q});
			rdv = reg_rdata_q;
			erv = reg_err_q;
			reg_wr = 0;
			reg_rd = 0;
			@(negedge core_clk);
		end
	endtask
	task wr(input [15:0] a, input [15:0] d);
		bus(1, a, d, 8'h01);
	endtask
	task rd(input [15:0] a, input [15:0] e);
		begin
			bus(0, a, 0, 8'h01);
			chk("rdata", e, rdv);
		end
	endtask
	// Status as running, fault, process-write enable
	task st(input [2:0] e);
		chk("status", {13'h0, e}, {13'h0, running_flag_q, wd_fault_q, pd_write_en_q});
	endtask
	task idle(input integer n);
		repeat (n) @(negedge core_clk);
	endtask
	task summarize;
		begin
			$display("tests %0d mismatches %0d", n_tests, n_mismatch);
			if (n_mismatch == 0 && n_tests > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		#50000;
		n_mismatch++;
		summarize;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		rst = 1;
		reg_rd = 0;
		reg_wr = 0;
		reg_addr = 0;
		reg_wdata = 0;
		reg_count = 1;
		idle(5);
		rst = 0;
		rd(16'h1003, 16'h0000);
		rd(16'h1004, 16'hffff);
		rd(16'h1005, 16'h0000);
		rd(16'h1006, 16'h0000);
		rd(16'h1007, 16'h0001);
		rd(16'h1008, 16'h0000);
		bus(0, 16'h1009, 0, 8'h01);
		chk("err", 1, {15'h0, erv});
		bus(1, 16'h1003, 1, 8'h02);
		chk("err", 1, {15'h0, erv});
		st(3'b001);
		wr(16'h1000, 16'h0003);
		wr(16'h1003, 16'h0001);
		st(3'b101);
		rd(16'h1006, 16'h0001);
		// Repeating the same word must not keep it alive; all of them land
		// before expiry, as a nonzero word after it would start it afresh
		repeat (8) begin idle(1); wr(16'h1003, 16'h0001); end
		idle(8);
		st(3'b010);
		rd(16'h1003, 16'h0000);
		rd(16'h1004, 16'h0000);
		wr(16'h1007, 16'h0001);
		chk("run", 1, {15'h0, running_flag_q});
		for (k = 0; k < 8; k++) begin idle(4); wr(16'h1003, k[15:0] & 16'h0001); end
		st(3'b101);
		wr(16'h1008, 16'haa55);
		st(3'b001);
		wr(16'h1007, 16'h0001);
		st(3'b001);
		wr(16'h1003, 16'h0002);
		wr(16'h1005, 16'haaaa);
		chk("run", 1, {15'h0, running_flag_q});
		wr(16'h1005, 16'h5555);
		st(3'b001);
		// Start by mask, kept alive by coil writes only
		wr(16'h1004, 16'h0007);
		rd(16'h1004, 16'h0007);
		wr(16'h1001, 16'h0010);
		st(3'b101);
		repeat (8) begin idle(4); m.fc(8'h05); end
		st(3'b101);
		rd(16'h1004, 16'h0003);
		wr(16'h1000, 16'h0009);
		rd(16'h1000, 16'h0003);
		wr(16'h1004, 16'h0009);
		st(3'b101);
		repeat (8) begin idle(4); m.fc(8'h06); end
		st(3'b010);
		wr(16'h1008, 16'h55aa);
		st(3'b001);
		// Upper mask half names codes that do not exist, so nothing starts
		wr(16'h1002, 16'h0001);
		wr(16'h1001, 16'h0010);
		st(3'b001);
		rd(16'h1002, 16'h0001);
		summarize;
	end
endmodule
